// ===== design/adcsm_pkg.sv
// ====================================================================
// Shared constants of the converter serial interface
package adcsm_pkg;

  // Result width and counter widths
  localparam int unsigned RES_BITS     = 18;
  localparam int unsigned BITCNT_W     = 5;
  localparam int unsigned CONVCNT_W    = 8;

  // Internal conversion time, independent of the serial clock
  localparam int unsigned CLK_PERIOD_NS = 25;
  localparam int unsigned CONV_TIME_NS  = 500;
  localparam int unsigned CONV_CYC      = (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Register byte offsets
  localparam logic [7:0] REG_CTRL     = 8'h00;
  localparam logic [7:0] REG_RESULT   = 8'h04;
  localparam logic [7:0] REG_STATUS   = 8'h08;
  localparam logic [7:0] REG_IRQ_STAT = 8'h0c;
  localparam logic [7:0] REG_IRQ_MASK = 8'h10;

  // Control fields and reset values
  localparam int unsigned CTRL_EN_BIT  = 0;
  localparam logic        CTRL_EN_RST  = 1'b1;

  // Status fields
  localparam int unsigned ST_PHASE_LSB = 0;
  localparam int unsigned ST_CHAIN_BIT = 2;
  localparam int unsigned ST_BUSY_BIT  = 3;
  localparam int unsigned ST_CBUSY_BIT = 4;

  // Interrupt events
  localparam int unsigned IRQ_W        = 3;
  localparam int unsigned IRQ_START    = 0;
  localparam int unsigned IRQ_DONE     = 1;
  localparam int unsigned IRQ_READ     = 2;
  localparam logic [2:0]  IRQ_MASK_RST = 3'h0;

  // Phases of one conversion and readout
  typedef enum logic [1:0] {
    PH_IDLE,
    PH_CONV,
    PH_HOLD,
    PH_SHIFT
  } adcsm_phase_e;

endpackage

// ===== design/adcsm_top.sv
// Function
// - Select mode works three-wire with only start line, clock and data output.
// - Select mode works four-wire; chain/select input gates readback independently.
// - Start line rising edge samples chain/select: high select mode, low chain mode.
// - Chain/select tied to the start line always yields chain mode.
// - Chain mode shifts chain/select input through, like one long shift register.
// - An optional start bit ahead of the result acts as busy indicator.
// - Select mode busy indicator enabled if start or select input low at conversion end.
// - Chain mode busy indicator enabled only if serial clock high at start edge.
// - Conversion is timed by the internal clock, serial clock not needed.
// - Start rising edge begins conversion, output released; conversion always completes (here a new start edge restarts it).
// - Without busy, MSB at select, later bits on falls, release after 18th fall.
// - Select mode with busy, output driven low at completion, then MSB first, 19th fall ends.
//
// Decided for this implementation: the register offsets and register access over Wishbone.
`timescale 1ns/10ps

module adcsm_top #(
  parameter int unsigned RES_W = adcsm_pkg::RES_BITS
) (
  input  wire logic        clk_i,
  input  wire logic        reset_n_i,
  // Wishbone classic slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  output logic             irq_o,
  // Converter pins
  input  wire logic        convert_start_line_i,
  input  wire logic        chain_select_input_i,
  input  wire logic        serial_clock_i,
  output logic             serial_result_output_o,
  output logic             serial_result_oe_n_o
);

  // ==================================================================
  // Elaboration checks
  // Shift register and bit counter are sized for at most 30 result bits
  if (RES_W < 2 || RES_W > 30) begin : g_bad_width
    $error("adcsm_top: RES_W must lie between 2 and 30");
  end
  if (adcsm_pkg::CONV_CYC < 1 || adcsm_pkg::CONV_CYC > 255) begin : g_bad_conv
    $error("adcsm_top: conversion count does not fit its counter");
  end

  // ==================================================================
  // State
  typedef struct packed {
    logic                                 cnv_s1;
    logic                                 cnv_s2;
    logic                                 cnv_s3;
    logic                                 sdi_s1;
    logic                                 sdi_s2;
    logic                                 sdi_s3;
    logic                                 sck_s1;
    logic                                 sck_s2;
    logic                                 sck_s3;
    adcsm_pkg::adcsm_phase_e              phase;
    logic                                 chain_mode;
    logic                                 busy_en;
    logic                                 chain_busy;
    logic [adcsm_pkg::CONVCNT_W-1:0]      conv_cnt;
    logic [adcsm_pkg::BITCNT_W-1:0]       bit_cnt;
    logic [RES_W:0]                       shreg;
    logic                                 sdi_cap;
    logic                                 serial_result_output;
    logic                                 sdo_oe_n;
    logic                                 ctrl_en;
    logic [RES_W-1:0]                     result;
    logic [adcsm_pkg::IRQ_W-1:0]          irq_stat;
    logic [adcsm_pkg::IRQ_W-1:0]          irq_mask;
    logic                                 ack;
    logic [31:0]                          rdata;
    logic                                 irq;
  } adcsm_state_s;

  localparam logic [adcsm_pkg::CONVCNT_W-1:0] CONV_LOAD =
    adcsm_pkg::CONVCNT_W'(adcsm_pkg::CONV_CYC - 1);
  localparam logic [adcsm_pkg::BITCNT_W-1:0]  LEN_PLAIN =
    adcsm_pkg::BITCNT_W'(RES_W);
  localparam logic [adcsm_pkg::BITCNT_W-1:0]  LEN_BUSY  =
    adcsm_pkg::BITCNT_W'(RES_W + 1);

  adcsm_state_s q;
  adcsm_state_s d;

  // ==================================================================
  // Edge detection on synchronised pins (second stage onward only)
  logic cnv_rise;
  logic sck_rise;
  logic sck_fall;
  logic sel_active;
  logic bus_hit;
  logic bus_wr;
  logic [31:0] wmask;
  logic [adcsm_pkg::IRQ_W-1:0] ev;
  logic [RES_W:0] shifted;

  assign cnv_rise   = q.cnv_s2 & ~q.cnv_s3;
  assign sck_rise   = q.sck_s2 & ~q.sck_s3;
  assign sck_fall   = ~q.sck_s2 & q.sck_s3;
  // Readback selected: start line low (3-wire) or select input low (4-wire)
  assign sel_active = ~q.cnv_s2 | ~q.sdi_s2;
  assign bus_hit    = wb_cyc_i & wb_stb_i & ~q.ack;
  assign bus_wr     = bus_hit & wb_we_i;
  assign wmask      = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  // Chain mode feeds the upstream bit in; select mode pads with zero
  // Chain without start bit skips the pad slot so upstream data follows the LSB directly
  assign shifted    = (q.chain_mode & ~q.busy_en) ? {q.shreg[RES_W-1:1], q.sdi_cap, 1'b0}
                                                  : {q.shreg[RES_W-1:0], q.chain_mode & q.sdi_cap};

  // ==================================================================
  // Next-state logic
  always_comb begin
    d  = q;
    ev = '0;

    // Two-flop synchronisers, third stage kept for edge detection and the pre-edge select sample
    d.cnv_s1 = convert_start_line_i;
    d.cnv_s2 = q.cnv_s1;
    d.cnv_s3 = q.cnv_s2;
    d.sdi_s1 = chain_select_input_i;
    d.sdi_s2 = q.sdi_s1;
    d.sdi_s3 = q.sdi_s2;
    d.sck_s1 = serial_clock_i;
    d.sck_s2 = q.sck_s1;
    d.sck_s3 = q.sck_s2;

    // Upstream bit is caught on the rising clock, shifted on the falling
    if (sck_rise) begin
      d.sdi_cap = q.sdi_s2;
    end

    case (q.phase)
      adcsm_pkg::PH_CONV: begin
        if (q.conv_cnt == '0) begin
          ev[adcsm_pkg::IRQ_DONE] = 1'b1;
          if (q.chain_mode) begin
            // Start bit high ahead of the code when busy was requested
            d.busy_en  = q.chain_busy;
            d.shreg    = q.chain_busy ? {1'b1, q.result} : {q.result, 1'b0};
            d.bit_cnt  = q.chain_busy ? LEN_BUSY : LEN_PLAIN;
            d.serial_result_output      = q.chain_busy ? 1'b1 : q.result[RES_W-1];
            d.sdo_oe_n = 1'b0;
            d.phase    = adcsm_pkg::PH_SHIFT;
          end else if (sel_active) begin
            // Busy: leave high impedance and drive the low start bit
            d.busy_en  = 1'b1;
            d.shreg    = {1'b0, q.result};
            d.bit_cnt  = LEN_BUSY;
            d.serial_result_output      = 1'b0;
            d.sdo_oe_n = 1'b0;
            d.phase    = adcsm_pkg::PH_SHIFT;
          end else begin
            // No busy: code waits until readback is selected
            d.busy_en  = 1'b0;
            d.shreg    = {q.result, 1'b0};
            d.bit_cnt  = LEN_PLAIN;
            d.phase    = adcsm_pkg::PH_HOLD;
          end
        end else begin
          d.conv_cnt = q.conv_cnt - 1'b1;
        end
      end
      adcsm_pkg::PH_HOLD: begin
        // MSB appears as soon as the host selects readback
        if (sel_active) begin
          d.serial_result_output      = q.shreg[RES_W];
          d.sdo_oe_n = 1'b0;
          d.phase    = adcsm_pkg::PH_SHIFT;
        end
      end
      adcsm_pkg::PH_SHIFT: begin
        if (!q.chain_mode && !sel_active) begin
          // Deselect ends the transfer early
          d.sdo_oe_n = 1'b1;
          d.serial_result_output      = 1'b0;
          d.phase    = adcsm_pkg::PH_IDLE;
        end else if (sck_fall) begin
          d.shreg = shifted;
          d.serial_result_output   = shifted[RES_W];
          if (q.bit_cnt != '0) begin
            d.bit_cnt = q.bit_cnt - 1'b1;
          end
          if (q.bit_cnt == 5'h01) begin
            ev[adcsm_pkg::IRQ_READ] = 1'b1;
            // Select mode releases after the last counted fall; chain keeps passing data
            if (!q.chain_mode) begin
              d.sdo_oe_n = 1'b1;
              d.serial_result_output      = 1'b0;
              d.phase    = adcsm_pkg::PH_IDLE;
            end
          end
        end
      end
      adcsm_pkg::PH_IDLE: begin
        d.phase = adcsm_pkg::PH_IDLE;
      end
      default: begin
        d.phase = adcsm_pkg::PH_IDLE;
      end
    endcase

    // Start edge wins over everything: new conversion, output released
    if (cnv_rise && q.ctrl_en) begin
      // Select input taken from before the edge, so a tied pair reads low
      d.chain_mode = ~q.sdi_s3;
      d.chain_busy = q.sck_s2;
      d.busy_en    = 1'b0;
      d.conv_cnt   = CONV_LOAD;
      d.sdo_oe_n   = 1'b1;
      d.serial_result_output        = 1'b0;
      d.phase      = adcsm_pkg::PH_CONV;
      ev[adcsm_pkg::IRQ_START] = 1'b1;
    end

    // Register writes; byte lanes honoured
    if (bus_wr) begin
      case (wb_adr_i)
        adcsm_pkg::REG_CTRL: begin
          if (wb_sel_i[0]) begin
            d.ctrl_en = wb_dat_i[adcsm_pkg::CTRL_EN_BIT];
          end
        end
        adcsm_pkg::REG_RESULT: begin
          d.result = RES_W'((32'(q.result) & ~wmask) | (wb_dat_i & wmask));
        end
        adcsm_pkg::REG_IRQ_STAT: begin
          if (wb_sel_i[0]) begin
            d.irq_stat = q.irq_stat & ~wb_dat_i[adcsm_pkg::IRQ_W-1:0];
          end
        end
        adcsm_pkg::REG_IRQ_MASK: begin
          if (wb_sel_i[0]) begin
            d.irq_mask = wb_dat_i[adcsm_pkg::IRQ_W-1:0];
          end
        end
        default: begin
          d.ctrl_en = q.ctrl_en;
        end
      endcase
    end

    // Events set after the clear so a same-cycle event is never lost
    d.irq_stat = d.irq_stat | ev;
    d.irq      = |(d.irq_stat & d.irq_mask);

    // Single-wait-state answer; unmapped reads return zero
    d.ack = bus_hit;
    if (bus_hit && !wb_we_i) begin
      case (wb_adr_i)
        adcsm_pkg::REG_CTRL: begin
          d.rdata = 32'(q.ctrl_en);
        end
        adcsm_pkg::REG_RESULT: begin
          d.rdata = 32'(q.result);
        end
        adcsm_pkg::REG_STATUS: begin
          d.rdata = '0;
          d.rdata[adcsm_pkg::ST_PHASE_LSB +: 2] = q.phase;
          d.rdata[adcsm_pkg::ST_CHAIN_BIT]      = q.chain_mode;
          d.rdata[adcsm_pkg::ST_BUSY_BIT]       = q.busy_en;
          d.rdata[adcsm_pkg::ST_CBUSY_BIT]      = q.chain_busy;
        end
        adcsm_pkg::REG_IRQ_STAT: begin
          d.rdata = 32'(q.irq_stat);
        end
        adcsm_pkg::REG_IRQ_MASK: begin
          d.rdata = 32'(q.irq_mask);
        end
        default: begin
          d.rdata = '0;
        end
      endcase
    end
  end

  // ==================================================================
  // State register
  // Reset takes constants only; output released, no conversion pending
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      q          <= '0;
      q.phase    <= adcsm_pkg::PH_IDLE;
      q.sdo_oe_n <= 1'b1;
      q.ctrl_en  <= adcsm_pkg::CTRL_EN_RST;
      q.irq_mask <= adcsm_pkg::IRQ_MASK_RST;
    end else begin
      q <= d;
    end
  end

  // ==================================================================
  // Outputs, all from flip-flops
  assign wb_dat_o               = q.rdata;
  assign wb_ack_o               = q.ack;
  assign irq_o                  = q.irq;
  assign serial_result_output_o = q.serial_result_output;
  assign serial_result_oe_n_o   = q.sdo_oe_n;

endmodule

// ===== test/adcsm_assertions.sv
`timescale 1ns/10ps
// ====================================================================
// Bus, interrupt and pin timing checks
module adcsm_checker (
  input wire logic        clk_i,
  input wire logic        reset_n_i,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic        irq_o,
  input wire logic        convert_start_line_i,
  input wire logic        serial_clock_i,
  input wire logic        serial_result_output_o,
  input wire logic        serial_result_oe_n_o
);
  logic       sck_q;
  logic [3:0] fall_age_q;

  // Cycles since the last serial clock fall; saturates so it never wraps
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      sck_q      <= 1'b0;
      fall_age_q <= 4'hf;
    end else begin
      sck_q      <= serial_clock_i;
      fall_age_q <= (sck_q && !serial_clock_i) ? 4'h0 : fall_age_q + {3'h0, fall_age_q != 4'hf};
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);

  // Bus handshake and read data
  property p_ack_next; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
  a_ack_next: assert property (p_ack_next) else $error("request not acked next cycle");
  property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
  property p_ack_cause; $rose(wb_ack_o) |-> $past(wb_stb_i); endproperty
  a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
  property p_dat_read; $changed(wb_dat_o) |-> wb_ack_o && !$past(wb_we_i); endproperty
  a_dat_read: assert property (p_dat_read) else $error("read data moved outside a read");
  // Sticky status: the line only drops after a register write
  property p_irq_sticky; $fell(irq_o) |-> $past(wb_we_i) && $past(wb_stb_i); endproperty
  a_irq_sticky: assert property (p_irq_sticky) else $error("interrupt dropped by itself");
  // Pin behaviour while converting and shifting
  property p_quiet; $rose(convert_start_line_i) |-> ##5 serial_result_oe_n_o [*8]; endproperty
  a_quiet: assert property (p_quiet) else $error("output driven after start edge");
  property p_conv_time; $rose(convert_start_line_i) |-> ##13 serial_result_oe_n_o [*8]; endproperty
  a_conv_time: assert property (p_conv_time) else $error("conversion ended early");
  property p_bit_hold;
    !serial_result_oe_n_o && !$past(serial_result_oe_n_o) && fall_age_q >= 4'h6 |-> $stable(serial_result_output_o);
  endproperty
  a_bit_hold: assert property (p_bit_hold) else $error("data bit moved without clock fall");
  c_read: cover property (wb_ack_o && !wb_we_i);
  c_drive: cover property ($fell(serial_result_oe_n_o));
  c_irq: cover property ($rose(irq_o));
endmodule

bind adcsm_top adcsm_checker u_checker (
  .clk_i(clk_i), .reset_n_i(reset_n_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .irq_o(irq_o), .convert_start_line_i(convert_start_line_i),
  .serial_clock_i(serial_clock_i), .serial_result_output_o(serial_result_output_o),
  .serial_result_oe_n_o(serial_result_oe_n_o));

// ===== test/adcsm_host_model.sv
`timescale 1ns/10ps
// ====================================================================
// Host side of the converter pins
module adcsm_host_model (
  input  wire logic clk_i,
  input  wire logic sdo_i,
  input  wire logic oe_n_i,
  output logic      cnv_o,
  output logic      sel_o,
  output logic      sck_o
);
  logic line_q = 1'b0;

  // A released line toggles, so a stale bit never reads as valid
  always @(posedge clk_i) line_q <= oe_n_i ? ~line_q : sdo_i;

  // Idle pins; serial clock stands still outside frames
  initial begin
    cnv_o = 1'b0;
    sel_o = 1'b1;
    sck_o = 1'b0;
  end

  // Start edge; c = {sel before, sel at edge, sck at edge, cnv after, sel after}
  task automatic start(input logic [4:0] c);
    cnv_o <= 1'b0;
    sel_o <= c[4];
    sck_o <= c[2];
    repeat (4) @(posedge clk_i);
    cnv_o <= 1'b1;
    sel_o <= c[3];
    repeat (4) @(posedge clk_i);
    cnv_o <= c[1];
    sel_o <= c[0];
    sck_o <= 1'b0;
  endtask

  // Wait out the conversion, then clock n bits in, MSB first
  task automatic shift(input int n, input logic c, input logic [31:0] pat, output logic [31:0] got);
    got = 32'h0;
    repeat (30) @(posedge clk_i);
    cnv_o <= c;
    sel_o <= pat[0];
    repeat (8) @(posedge clk_i);
    for (int i = 0; i < n; i++) begin
      sck_o <= 1'b1;
      repeat (4) @(posedge clk_i);
      got = {got[30:0], line_q};
      sck_o <= 1'b0;
      sel_o <= pat[i+1];
      repeat (4) @(posedge clk_i);
    end
  endtask
endmodule

// ===== test/testbench.sv
`timescale 1ns/10ps
// ====================================================================
// Self-checking bench for the converter interface
module testbench;
  logic        clk_i = 1'b0;
  logic        reset_n_i;
  logic        cyc;
  logic        stb;
  logic        we;
  logic [7:0]  adr;
  logic [3:0]  sel;
  logic [31:0] dat;
  logic [31:0] rd;
  logic [31:0] q;
  logic        ack;
  logic        irq;
  logic        convert_start_line;
  logic        csel;
  logic        sck;
  logic        serial_result_output;
  logic        oe_n;
  int          n_fail = 0;
  int          comparisons = 0;

  // 40 MHz clock
  always #12.5 clk_i = ~clk_i;

  adcsm_top DUT (
    .clk_i(clk_i), .reset_n_i(reset_n_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rd), .wb_ack_o(ack), .irq_o(irq),
    .convert_start_line_i(convert_start_line), .chain_select_input_i(csel), .serial_clock_i(sck),
    .serial_result_output_o(serial_result_output), .serial_result_oe_n_o(oe_n));
  adcsm_host_model host (.clk_i(clk_i), .sdo_i(serial_result_output), .oe_n_i(oe_n), .cnv_o(convert_start_line), .sel_o(csel), .sck_o(sck));

  // ====================================================================
  // Checking and bus tasks
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic results();
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // Classic cycle: hold until ack; only the watchdog ends a wait on a dead slave
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    do begin
      @(posedge clk_i);
    end while (ack !== 1'b1);
    q = rd;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic rdchk(input string what, input logic [7:0] a, input logic [31:0] exp);
    wb(1'b0, a, 32'h0);
    check(what, q, exp);
  endtask

  // Pin settings per scenario: 3-wire, 3-wire busy, chain tied, 4-wire, 4-wire busy, chain busy
  function automatic logic [4:0] cfg_of(int m);
    case (m)
      1: return 5'b11001;
      2: return 5'b01011;
      4: return 5'b11010;
      5: return 5'b00110;
      default: return 5'b11011;
    endcase
  endfunction

  // Serial word the host should collect
  function automatic logic [31:0] expect_word(int m, logic [17:0] r, logic [31:0] p);
    case (m)
      2: return {10'h0, r, p[0], p[1], p[2], p[3]};
      5: return {13'h0, 1'b1, r};
      default: return {14'h0, r};
    endcase
  endfunction

  // Runaway guard, far past the roughly 35 us the sequence needs
  initial begin
    #500000;
    n_fail++;
    results();
  end

  // ====================================================================
  // Main sequence
  initial begin
    logic [17:0] res;
    logic [31:0] pat;
    logic [31:0] got;
    logic        busy;
    logic        chain;
    reset_n_i = 1'b0;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 8'h0;
    sel = 4'hf;
    dat = 32'h0;
    q = $urandom(32'h46c6bdb9);
    repeat (8) @(posedge clk_i);
    reset_n_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    rdchk("ctrl", adcsm_pkg::REG_CTRL, 32'h1);
    rdchk("result", adcsm_pkg::REG_RESULT, 32'h0);
    // Only the enabled byte lane may change the result register
    sel <= 4'h2;
    wb(1'b1, adcsm_pkg::REG_RESULT, 32'hffffffff);
    sel <= 4'hf;
    rdchk("byte lane", adcsm_pkg::REG_RESULT, 32'h0000ff00);
    wb(1'b1, adcsm_pkg::REG_RESULT, 32'h0);
    rdchk("irq_stat", adcsm_pkg::REG_IRQ_STAT, 32'h0);
    rdchk("irq_mask", adcsm_pkg::REG_IRQ_MASK, 32'h0);
    wb(1'b1, 8'h14, $urandom);
    rdchk("unmapped", 8'h14, 32'h0);
    // Start edges are ignored while disabled
    wb(1'b1, adcsm_pkg::REG_CTRL, 32'h0);
    host.start(5'b11011);
    rdchk("disabled", adcsm_pkg::REG_STATUS, 32'h0);
    wb(1'b1, adcsm_pkg::REG_CTRL, 32'h1);
    wb(1'b1, adcsm_pkg::REG_IRQ_MASK, 32'h2);
    for (int m = 0; m < 6; m++) begin
      busy = m inside {1, 4, 5};
      chain = m inside {2, 5};
      res = 18'($urandom);
      pat = (m < 2) ? 32'hffffffff : ((m == 2) ? $urandom : 32'h0);
      wb(1'b1, adcsm_pkg::REG_RESULT, {14'($urandom), res});
      rdchk("result", adcsm_pkg::REG_RESULT, {14'h0, res});
      host.start(cfg_of(m));
      repeat (2) @(posedge clk_i);
      check("released", 32'(oe_n), 32'h1);
      host.shift((m == 2) ? 22 : (busy ? 19 : 18), m > 1, pat, got);
      check("word", got, expect_word(m, res, pat));
      repeat (2) @(posedge clk_i);
      if (!chain) check("frame end", 32'(oe_n), 32'h1);
      wb(1'b0, adcsm_pkg::REG_STATUS, 32'h0);
      check("mode", {29'h0, q[4:2]}, {29'h0, m == 5, busy, chain});
      check("irq set", 32'(irq), 32'h1);
      rdchk("events", adcsm_pkg::REG_IRQ_STAT, 32'h7);
      wb(1'b1, adcsm_pkg::REG_IRQ_STAT, 32'h7);
      rdchk("events cleared", adcsm_pkg::REG_IRQ_STAT, 32'h0);
      check("irq clear", 32'(irq), 32'h0);
    end
    results();
  end
endmodule
